// ### kped_pkg.sv
`default_nettype none
package kped_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_DIRECT   = 8'h08;
   localparam logic [7:0] OFS_DEBOUNCE = 8'h0c;
   localparam logic [7:0] OFS_ENCODER  = 8'h10;
   localparam logic [7:0] OFS_SCAN_LO  = 8'h14;
   localparam logic [7:0] OFS_SCAN_HI  = 8'h18;
   // keypad_control_reg fields
   localparam int CTRL_DIE     = 0;
   localparam int CTRL_MIE     = 1;
   localparam int CTRL_DEBSEL  = 2;
   localparam int CTRL_ZERODEB = 3;
   localparam int CTRL_AUTOACT = 4;
   localparam int CTRL_SWSCAN  = 5;
   localparam int CTRL_DFLAG   = 6;
   localparam int CTRL_MFLAG   = 7;
   localparam int CTRL_COL_LSB = 8;
   localparam logic [7:0] COL_RESET = 8'hff;
   // encoder_count_reg fields
   localparam int ENC_CNT0_LSB = 0;
   localparam int ENC_UF0      = 8;
   localparam int ENC_OF0      = 9;
   localparam int ENC_CNT1_LSB = 16;
   localparam int ENC_UF1      = 24;
   localparam int ENC_OF1      = 25;
   // debounce_interval_reg fields
   localparam int DEB_MAT_LSB = 0;
   localparam int DEB_DIR_LSB = 8;
   // status fields
   localparam int STAT_ANYKEY = 0;
   localparam int STAT_BUSY   = 1;
   // keypad clock derived from the core clock
   localparam int CORE_KHZ    = 125000;
   localparam int KPAD_KHZ    = 32;
   localparam int TICK_CYCLES = CORE_KHZ / KPAD_KHZ;
   localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_MIN = 8'h00;

   typedef enum logic [1:0] {KPED_IDLE, KPED_SCAN0, KPED_WAIT, KPED_SCAN1}
      kped_phase_t;

   // key = {prev a, prev b, cur a, cur b}
   function automatic logic kped_is_up(input logic [3:0] key);
      return (key == 4'h1) || (key == 4'h7) || (key == 4'h8) ||
             (key == 4'he);
   endfunction
   function automatic logic kped_is_dn(input logic [3:0] key);
      return (key == 4'h2) || (key == 4'h4) || (key == 4'hb) ||
             (key == 4'hd);
   endfunction
endpackage
`default_nettype wire

// ### kped_deb_if.sv
`timescale 1ns/10ps
`default_nettype none
interface kped_deb_if #(parameter int W = 8);
   logic         tick;
   logic [7:0]   interval;
   logic [W-1:0] sample;
   logic [W-1:0] stable;
   logic         changed;
   modport chk  (input tick, interval, sample, output stable, changed);
   modport user (output tick, interval, sample, input stable, changed);
endinterface
`default_nettype wire

// ### kped_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module kped_debounce #(parameter int W = 8) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // checked input and result
   kped_deb_if.chk  port
);
   import kped_pkg::*;

   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] stable;
      logic [7:0]   cnt;
      logic         waiting;
      logic         changed;
   } kped_dbs_t;

   kped_dbs_t s;
   kped_dbs_t next_s;

   always_comb begin
      next_s = s;
      next_s.changed = 1'b0;
      if (port.tick) begin
         if (port.interval == 8'h00) begin
            // no interval: every sample passes straight through
            if (port.sample != s.stable) begin
               next_s.stable  = port.sample;
               next_s.changed = 1'b1;
            end
            next_s.first   = port.sample;
            next_s.waiting = 1'b0;
         end else if (!s.waiting) begin
            next_s.first   = port.sample;
            next_s.waiting = 1'b1;
            next_s.cnt     = 8'h01;
         end else if (s.cnt < port.interval) begin
            next_s.cnt = s.cnt + 8'h01;
         end else begin
            // one interval since the last sample: compare and resample
            if (port.sample == s.first && port.sample != s.stable) begin
               next_s.stable  = port.sample;
               next_s.changed = 1'b1;
            end
            next_s.first = port.sample;
            next_s.cnt   = 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign port.stable  = s.stable;
   assign port.changed = s.changed;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_accept_sample: assert property (s.changed |-> s.stable == $past(port.sample)) else $error("accepted value is not the sampled one");
   a_mismatch_hold: assert property ((port.tick && port.interval != 8'h00 && s.waiting && s.cnt >= port.interval && port.sample != s.first) |=> !s.changed) else $error("accepted without two matching samples");
   a_zero_pass: assert property ((port.tick && port.interval == 8'h00 && port.sample != s.stable) |=> (s.changed && s.stable == $past(port.sample))) else $error("zero interval did not pass input");
endmodule
`default_nettype wire

// ### kped_top.sv
// What this block does
// - Prev/current A,B pairs decode to count up, count down, or no change.
// - Each encoder counter updates once per keypad clock tick.
// - Encoder register holds two counts, each with underflow and overflow.
// - Down count below zero flags underflow.
// - Up count above 255 flags overflow.
// - Interval field zero disables debounce checking.
// - Inputs count as debounced only when two samples a full interval apart match.
// - Manual matrix mode stores only whether any key is pressed.
// - Manual any-key status sampled, interval waited, resampled until match.
// - Activity-started scans debounce; software-started single scan does not.
// - Activity scan: scan, wait, rescan until two full scans match.
// - Direct lines sampled, interval waited, resampled until samples agree.
// - One keypad interrupt merges matrix and direct flags.
// - Each flag is gated by its own enable before merging.
// - Keypad timing counts periods of a 32 kHz keypad clock.
// - Debounced direct or encoder activity sets the direct flag.
// - Encoder sensors come from direct inputs 3 down to 0.
// - Debounce select picks direct or matrix interval; zero select skips it for encoders.
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module kped_top (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // ahb-lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output var  logic [31:0] HRDATA,
   output var  logic        HREADYOUT,
   output var  logic        HRESP,
   // keypad pins
   input  wire logic [7:0]  MATRIX_ROW_IN,
   input  wire logic [7:0]  DIRECT_KEY_IN,
   output var  logic [7:0]  MATRIX_COLUMN_OUT,
   // interrupt
   output var  logic        KEYPAD_IRQ
);
   import kped_pkg::*;

   typedef struct packed {
      logic [7:0]       row_s1;
      logic [7:0]       row_s2;
      logic [7:0]       dk_s1;
      logic [7:0]       dk_s2;
      logic [11:0]      div;
      logic             tick;
      logic             direct_irq_enable;
      logic             matrix_irq_enable;
      logic             debsel;
      logic             zerodeb;
      logic             autoact;
      logic             swscan;
      logic             dflag;
      logic             mflag;
      logic [7:0]       columns;
      logic [7:0]       mint;
      logic [7:0]       dint;
      logic [1:0][7:0]  enc_cnt;
      logic [1:0]       enc_uf;
      logic [1:0]       enc_of;
      logic [3:0]       enc_prev;
      kped_phase_t      phase;
      logic [2:0]       col;
      logic [7:0]       wcnt;
      logic             single;
      logic [63:0]      res0;
      logic [63:0]      res1;
      logic [63:0]      report;
      logic [7:0]       col_out;
      logic             dp_wr;
      logic [7:0]       dp_addr;
      logic [31:0]      hrdata;
      logic             hreadyout;
      logic             hresp;
      logic             irq;
   } kped_st_t;

   kped_st_t   s;
   kped_st_t   next_s;
   logic [3:0] enc_src;
   logic       addr_ok;

   kped_deb_if #(.W(8)) dir_if ();
   kped_deb_if #(.W(1)) man_if ();

   // direct keys, and encoders unless zero debounce is selected
   assign dir_if.tick     = s.tick;
   assign dir_if.interval = s.debsel ? s.dint : s.mint;
   assign dir_if.sample   = s.dk_s2;
   // manual mode watches only the any-key level
   assign man_if.tick     = s.tick;
   assign man_if.interval = s.mint;
   assign man_if.sample   = |s.row_s2;

   kped_debounce #(.W(8)) u_dir_deb (
      .clk  (CORE_CLK),
      .rst  (RST),
      .port (dir_if.chk)
   );
   kped_debounce #(.W(1)) u_man_deb (
      .clk  (CORE_CLK),
      .rst  (RST),
      .port (man_if.chk)
   );

   assign enc_src = s.zerodeb ? s.dk_s2[3:0] : dir_if.stable[3:0];
   assign addr_ok = HSEL && HTRANS[1] && HREADY;

   always_comb begin
      logic [31:0] rd;
      logic [3:0]  key;
      logic        moved;
      rd    = 32'h0000_0000;
      key   = 4'h0;
      moved = 1'b0;
      next_s = s;
      // keypad clock tick
      next_s.tick = (s.div == TICK_LAST);
      next_s.div  = next_s.tick ? 12'h000 : s.div + 12'h001;
      next_s.row_s1 = MATRIX_ROW_IN;
      next_s.row_s2 = s.row_s1;
      next_s.dk_s1  = DIRECT_KEY_IN;
      next_s.dk_s2  = s.dk_s1;
      // data phase of a write
      if (s.dp_wr) begin
         case (s.dp_addr)
            OFS_CTRL: begin
               next_s.direct_irq_enable     = HWDATA[CTRL_DIE];
               next_s.matrix_irq_enable     = HWDATA[CTRL_MIE];
               next_s.debsel  = HWDATA[CTRL_DEBSEL];
               next_s.zerodeb = HWDATA[CTRL_ZERODEB];
               next_s.autoact = HWDATA[CTRL_AUTOACT];
               next_s.swscan  = HWDATA[CTRL_SWSCAN];
               next_s.columns = HWDATA[CTRL_COL_LSB +: 8];
               if (HWDATA[CTRL_DFLAG]) next_s.dflag = 1'b0;
               if (HWDATA[CTRL_MFLAG]) next_s.mflag = 1'b0;
            end
            OFS_DEBOUNCE: begin
               next_s.mint = HWDATA[DEB_MAT_LSB +: 8];
               next_s.dint = HWDATA[DEB_DIR_LSB +: 8];
            end
            OFS_ENCODER: begin
               next_s.enc_cnt[0] = HWDATA[ENC_CNT0_LSB +: 8];
               next_s.enc_cnt[1] = HWDATA[ENC_CNT1_LSB +: 8];
               if (HWDATA[ENC_UF0]) next_s.enc_uf[0] = 1'b0;
               if (HWDATA[ENC_OF0]) next_s.enc_of[0] = 1'b0;
               if (HWDATA[ENC_UF1]) next_s.enc_uf[1] = 1'b0;
               if (HWDATA[ENC_OF1]) next_s.enc_of[1] = 1'b0;
            end
            default: ;
         endcase
      end
      // encoders: hardware events come after the write, so sets win
      if (s.tick) begin
         next_s.enc_prev = enc_src;
         for (int e = 0; e < 2; e++) begin
            key = {s.enc_prev[2*e], s.enc_prev[2*e+1],
                   enc_src[2*e], enc_src[2*e+1]};
            if (kped_is_up(key)) begin
               moved = 1'b1;
               if (next_s.enc_cnt[e] == CNT_MAX) begin
                  next_s.enc_cnt[e] = CNT_MIN;
                  next_s.enc_of[e]  = 1'b1;
               end else begin
                  next_s.enc_cnt[e] = next_s.enc_cnt[e] + 8'h01;
               end
            end else if (kped_is_dn(key)) begin
               moved = 1'b1;
               if (next_s.enc_cnt[e] == CNT_MIN) begin
                  next_s.enc_cnt[e] = CNT_MAX;
                  next_s.enc_uf[e]  = 1'b1;
               end else begin
                  next_s.enc_cnt[e] = next_s.enc_cnt[e] - 8'h01;
               end
            end
         end
      end
      if (dir_if.changed || moved) next_s.dflag = 1'b1;
      // matrix scanning; a column is scanned by driving it alone
      case (s.phase)
         KPED_IDLE: begin
            if (s.swscan) begin
               next_s.swscan  = 1'b0;
               next_s.single  = 1'b1;
               next_s.phase   = KPED_SCAN0;
               next_s.col     = 3'h0;
               next_s.col_out = 8'h01;
            end else if (s.autoact && s.tick &&
                         ((|s.row_s2) != (|s.report))) begin
               next_s.single  = 1'b0;
               next_s.phase   = KPED_SCAN0;
               next_s.col     = 3'h0;
               next_s.col_out = 8'h01;
            end else if (!s.autoact && man_if.changed) begin
               next_s.mflag = 1'b1;
            end
         end
         KPED_SCAN0, KPED_SCAN1: begin
            if (s.tick) begin
               if (s.phase == KPED_SCAN0) begin
                  next_s.res0[{s.col, 3'b000} +: 8] = s.row_s2;
               end else begin
                  next_s.res1[{s.col, 3'b000} +: 8] = s.row_s2;
               end
               if (s.col != 3'h7) begin
                  next_s.col     = s.col + 3'h1;
                  next_s.col_out = {s.col_out[6:0], 1'b0};
               end else if (s.phase == KPED_SCAN0 &&
                            (s.single || s.mint == 8'h00)) begin
                  // single software scan reports without debounce or irq
                  if (!s.single && next_s.res0 != s.report) begin
                     next_s.mflag = 1'b1;
                  end
                  next_s.report = next_s.res0;
                  next_s.phase  = KPED_IDLE;
               end else if (s.phase == KPED_SCAN0) begin
                  next_s.phase = KPED_WAIT;
                  next_s.wcnt  = 8'h01;
               end else if (next_s.res1 == s.res0) begin
                  if (next_s.res1 != s.report) begin
                     next_s.report = next_s.res1;
                     next_s.mflag  = 1'b1;
                  end
                  next_s.phase = KPED_IDLE;
               end else begin
                  next_s.res0  = next_s.res1;
                  next_s.phase = KPED_WAIT;
                  next_s.wcnt  = 8'h01;
               end
            end
         end
         KPED_WAIT: begin
            if (s.tick) begin
               if (s.wcnt < s.mint) begin
                  next_s.wcnt = s.wcnt + 8'h01;
               end else begin
                  next_s.phase   = KPED_SCAN1;
                  next_s.col     = 3'h0;
                  next_s.col_out = 8'h01;
               end
            end
         end
         default: next_s.phase = KPED_IDLE;
      endcase
      // columns follow software while no automatic scan drives them
      if (next_s.phase == KPED_IDLE || next_s.phase == KPED_WAIT) begin
         next_s.col_out = next_s.columns;
      end
      next_s.irq = (s.mflag && s.matrix_irq_enable) || (s.dflag && s.direct_irq_enable);
      // address phase; zero wait states
      next_s.hreadyout = 1'b1;
      next_s.hresp     = 1'b0;
      next_s.dp_wr     = addr_ok && HWRITE;
      next_s.dp_addr   = HADDR[7:0];
      case (HADDR[7:0])
         OFS_CTRL: begin
            rd[CTRL_DIE]     = s.direct_irq_enable;
            rd[CTRL_MIE]     = s.matrix_irq_enable;
            rd[CTRL_DEBSEL]  = s.debsel;
            rd[CTRL_ZERODEB] = s.zerodeb;
            rd[CTRL_AUTOACT] = s.autoact;
            rd[CTRL_SWSCAN]  = s.swscan;
            rd[CTRL_DFLAG]   = s.dflag;
            rd[CTRL_MFLAG]   = s.mflag;
            rd[CTRL_COL_LSB +: 8] = s.columns;
         end
         OFS_STATUS: begin
            rd[STAT_ANYKEY] = man_if.stable[0];
            rd[STAT_BUSY]   = (s.phase != KPED_IDLE);
         end
         OFS_DIRECT: rd[7:0] = dir_if.stable;
         OFS_DEBOUNCE: begin
            rd[DEB_MAT_LSB +: 8] = s.mint;
            rd[DEB_DIR_LSB +: 8] = s.dint;
         end
         OFS_ENCODER: begin
            rd[ENC_CNT0_LSB +: 8] = s.enc_cnt[0];
            rd[ENC_UF0]           = s.enc_uf[0];
            rd[ENC_OF0]           = s.enc_of[0];
            rd[ENC_CNT1_LSB +: 8] = s.enc_cnt[1];
            rd[ENC_UF1]           = s.enc_uf[1];
            rd[ENC_OF1]           = s.enc_of[1];
         end
         OFS_SCAN_LO: rd = s.report[31:0];
         OFS_SCAN_HI: rd = s.report[63:32];
         default: rd = 32'h0000_0000;
      endcase
      next_s.hrdata = (addr_ok && !HWRITE) ? rd : 32'h0000_0000;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         s           <= '0;
         s.columns   <= COL_RESET;
         s.col_out   <= COL_RESET;
         s.hreadyout <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign HRDATA            = s.hrdata;
   assign HREADYOUT         = s.hreadyout;
   assign HRESP             = s.hresp;
   assign MATRIX_COLUMN_OUT = s.col_out;
   assign KEYPAD_IRQ        = s.irq;

   // helpers read only by the checks below
   logic enc_up0;
   logic enc_dn0;
   logic wr_enc;
   logic scan_end;
   assign enc_up0  = kped_is_up({s.enc_prev[0], s.enc_prev[1],
                                 enc_src[0], enc_src[1]});
   assign enc_dn0  = kped_is_dn({s.enc_prev[0], s.enc_prev[1],
                                 enc_src[0], enc_src[1]});
   assign wr_enc   = s.dp_wr && (s.dp_addr == OFS_ENCODER);
   assign scan_end = s.tick && (s.col == 3'h7);

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence seq_scan1_done;
      (s.phase == KPED_SCAN1) && scan_end;
   endsequence
   sequence seq_single_done;
      (s.phase == KPED_SCAN0) && s.single && scan_end;
   endsequence

   a_irq_matrix: assert property ((s.mflag && s.matrix_irq_enable) |=> KEYPAD_IRQ) else $error("enabled matrix flag gave no irq");
   a_irq_gated: assert property ((!(s.mflag && s.matrix_irq_enable) && !(s.dflag && s.direct_irq_enable)) |=> !KEYPAD_IRQ) else $error("irq without enabled flag");
   a_enc_up: assert property ((s.tick && enc_up0 && !wr_enc && s.enc_cnt[0] != CNT_MAX) |=> s.enc_cnt[0] == $past(s.enc_cnt[0]) + 8'h01) else $error("encoder did not count up");
   a_enc_hold: assert property ((s.tick && !enc_up0 && !enc_dn0 && !wr_enc) |=> $stable(s.enc_cnt[0])) else $error("encoder count moved without step");
   a_enc_ovf: assert property ((s.tick && enc_up0 && !wr_enc && s.enc_cnt[0] == CNT_MAX) |=> (s.enc_cnt[0] == CNT_MIN && s.enc_of[0])) else $error("overflow not wrapped or flagged");
   a_enc_unf: assert property ((s.tick && enc_dn0 && !wr_enc && s.enc_cnt[0] == CNT_MIN) |=> (s.enc_cnt[0] == CNT_MAX && s.enc_uf[0])) else $error("underflow not wrapped or flagged");
   a_flag_sticky: assert property ((s.enc_of[0] && !wr_enc) |=> s.enc_of[0]) else $error("overflow flag lost");
   a_scan_retry: assert property ((seq_scan1_done and (next_s.res1 != s.res0)) |=> (s.phase == KPED_WAIT && s.wcnt == 8'h01)) else $error("mismatched scans not retried");
   a_single_noirq: assert property ((seq_single_done and !s.mflag and !s.dp_wr) |=> (s.phase == KPED_IDLE && !s.mflag)) else $error("software scan raised matrix flag");
   a_direct_flag: assert property (dir_if.changed |=> s.dflag) else $error("direct activity did not set flag");
   a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not ready or error response");
endmodule
`default_nettype wire

// ### kped_keys.sv
`timescale 1ns/10ps
`default_nettype none
module kped_keys (
   // clock
   input  wire logic        clk,
   // bench stimulus: step = {dn1, up1, dn0, up0}
   input  wire logic [3:0]  step,
   input  wire logic [3:0]  keys_hi,
   input  wire logic [63:0] pressed,
   // keypad pins
   input  wire logic [7:0]  cols,
   output var  logic [7:0]  direct_key_in,
   output var  logic [7:0]  rows
);
   logic [1:0] ph0 = 2'h0;
   logic [1:0] ph1 = 2'h0;
   always_ff @(posedge clk) begin
      ph0 <= ph0 + 2'(step[0]) - 2'(step[1]);
      ph1 <= ph1 + 2'(step[2]) - 2'(step[3]);
   end
   // gray order: only one sensor moves per step, as a real rotor does
   assign direct_key_in = {keys_hi, ph1[1] ^ ph1[0], ph1[1], ph0[1] ^ ph0[0], ph0[1]};
   // a pressed key shorts its driven column onto its row
   always_comb begin
      rows = 8'h00;
      for (int c = 0; c < 8; c++) begin
         if (cols[c]) begin
            rows = rows | pressed[c*8 +: 8];
         end
      end
   end
endmodule
`default_nettype wire

// ### keypad_encoder_debounce_tb.sv
`timescale 1ns/10ps
`default_nettype none
module keypad_encoder_debounce_tb;
   import kped_pkg::*;
   logic        CORE_CLK = 1'b0;
   logic        RST = 1'b1;
   logic        HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0]  HTRANS = 2'h0;
   logic        HWRITE = 1'b0;
   logic [2:0]  HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h0;
   logic        HREADY;
   logic [31:0] HRDATA;
   logic        HREADYOUT;
   logic        HRESP;
   logic [7:0]  rows;
   logic [7:0]  direct_key_in;
   logic [7:0]  cols;
   logic        irq;
   logic [3:0]  step = 4'h0;
   logic [3:0]  keys_hi = 4'h0;
   logic [63:0] pressed = 64'h0;
   logic [31:0] q;
   logic [3:0]  fl = 4'h0;
   logic [3:0]  k;
   int          err_total = 0;
   int          compares = 0;
   int          c0;
   int          c1;
   int          seed = 32'ha03d;
   initial forever #4 CORE_CLK = ~CORE_CLK;
   assign HREADY = HREADYOUT;
   kped_top DUT (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
      .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .MATRIX_ROW_IN(rows), .DIRECT_KEY_IN(direct_key_in),
      .MATRIX_COLUMN_OUT(cols), .KEYPAD_IRQ(irq));
   kped_keys keys (.clk(CORE_CLK), .step(step), .keys_hi(keys_hi),
      .pressed(pressed), .cols(cols), .direct_key_in(direct_key_in), .rows(rows));
   task automatic results;
      $display("%0d mismatches in %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 64);
      if (HREADYOUT !== 1'b1) begin
         err_total++;
         results();
      end
   endtask
   // one single word transfer; read data lands in q
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= w;
      HADDR <= {24'h0, a};
      wait_rdy();
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      wait_rdy();
      q = HRDATA;
   endtask
   task automatic tk(input int n);
      repeat (n * TICK_CYCLES) @(posedge CORE_CLK);
   endtask
   initial begin
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(posedge CORE_CLK);
      // look mid-cycle so the launching edge cannot race the compare
      @(negedge CORE_CLK);
      chk({23'h0, irq, cols}, 32'h0ff);
      chk({30'h0, HREADYOUT, HRESP}, 32'h2);
      @(posedge CORE_CLK);
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'hff00);
      ahb(1'b0, 8'h1c, 32'h0);
      chk(q, 32'h0);
      // matrix and direct debounce intervals both set to one keypad clock tick
      ahb(1'b1, OFS_DEBOUNCE, 32'h0101);
      // raw encoder pins, so one step lands per tick
      ahb(1'b1, OFS_CTRL, 32'hff09);
      for (int i = 0; i < 2; i++) begin
         c0 = (i == 0) ? 255 : ($random(seed) & 255);
         c1 = (i == 0) ? 0 : ($random(seed) & 255);
         ahb(1'b1, OFS_ENCODER, {8'h0, 8'(c1), 8'h0, 8'(c0)});
         step <= 4'b1001;
         @(posedge CORE_CLK);
         step <= 4'h0;
         tk(2);
         fl = fl | {1'b0, c1 == 0, c0 == 255, 1'b0};
         c0 = (c0 + 1) & 255;
         c1 = (c1 + 255) & 255;
         ahb(1'b0, OFS_ENCODER, 32'h0);
         chk(q, {6'h0, fl[3:2], 8'(c1), 6'h0, fl[1:0], 8'(c0)});
         chk({31'h0, irq}, 32'h1);
      end
      k = 4'($random(seed));
      keys_hi <= k;
      tk(3);
      ahb(1'b1, OFS_CTRL, 32'hff08);
      repeat (3) @(posedge CORE_CLK);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b0, OFS_DIRECT, 32'h0);
      chk(q, {24'h0, k, 4'hf});
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'hff48);
      // clear both flags, matrix enable only, then hold one key
      ahb(1'b1, OFS_CTRL, 32'hffc2);
      pressed[42] <= 1'b1;
      tk(3);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk(q, 32'h1);
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'hff82);
      chk({31'h0, irq}, 32'h1);
      // one software scan: key at column 5, row 2; no flag of its own
      ahb(1'b1, OFS_CTRL, 32'hff22);
      tk(10);
      ahb(1'b0, OFS_SCAN_HI, 32'h0);
      chk(q, 32'h0000_0400);
      ahb(1'b0, OFS_SCAN_LO, 32'h0);
      chk(q, 32'h0);
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'hff82);
      results();
   end
endmodule
`default_nettype wire
